// [bench/cond_fp_store_and_xar_prefix_bench.sv]
module cond_fp_store_and_xar_prefix_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic slow = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic ack, ready, mvalid, mdbl, mext, tvalid, gap, evalid, trap_seen;
	logic [31:0] rdat, maddr, rd_val;
	logic [63:0] mdata;
	logic [2:0] tcode;
	int num_errors = 0;
	int cmp_count = 0;
	int gap_count = 0;
	always #5 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		if (gap === 1'b1) begin
			gap_count <= gap_count + 1;
		end
	end
	cond_fp_store_and_xar_prefix uut (.i_clock(i_clock), .i_rst(i_rst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
		.i_mem_ready(ready), .o_mem_valid(mvalid), .o_mem_addr(maddr),
		.o_mem_data(mdata), .o_mem_double(mdbl), .o_mem_ext(mext),
		.o_trap_valid(tvalid), .o_trap_code(tcode), .o_gap_trap(gap),
		.o_ext_valid(evalid));
	lsu_model lsu (.i_clock(i_clock), .i_rst(i_rst), .i_slow(slow),
		.i_valid(mvalid), .i_addr(maddr), .i_data(mdata), .i_double(mdbl),
		.i_ext(mext), .o_ready(ready));
	// ==========================================================
	// Shared helpers.
	task finish_test;
		$display("compares %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		i = 0;
		do begin
			@(posedge i_clock);
			i++;
		end while (ack !== 1'b1 && i < 100);
		if (ack !== 1'b1) begin
			num_errors++;
			$display("wrong value ack: expected 1, seen none");
			finish_test();
		end
		rd_val = rdat;
		trap_seen = tvalid;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge i_clock);
	endtask : wb
	task store_case(input logic [5:0] op3, input logic [31:0] base,
		input logic [7:0] simm, input logic cnd, input logic [5:0] ctl,
		input logic [2:0] code, input int nst);
		int n0;
		int i;
		n0 = lsu.count;
		wb(1'b1, cond_fp_store_pkg::OFS_STATUS, 32'h0000_01FF);
		wb(1'b1, cond_fp_store_pkg::OFS_BASE, base);
		wb(1'b1, cond_fp_store_pkg::OFS_COND, {cnd, 31'h0000_0000});
		wb(1'b1, cond_fp_store_pkg::OFS_CTRL, {26'h000_0000, ctl});
		wb(1'b1, cond_fp_store_pkg::OFS_INSN,
			{2'b11, 5'h00, op3, 5'h00, 1'b1, simm, 5'h00});
		chk("trap pulse", code != 3'h0, trap_seen);
		if (code != 3'h0) chk("trap code", code, tcode);
		i = 0;
		while (lsu.count < n0 + nst && i < 50) begin
			@(posedge i_clock);
			i++;
		end
		if (lsu.count < n0 + nst) begin
			num_errors++;
			$display("wrong value store count: expected %0d, seen timeout", nst);
			finish_test();
		end
		repeat (4) @(posedge i_clock);
		chk("store count", nst, lsu.count - n0);
	endtask : store_case
	task st_chk(input int n, input logic [31:0] a, input logic [63:0] d,
		input logic dbl, input logic ext);
		chk("store addr", a, lsu.addr_q[n % 16]);
		chk("store data", d, lsu.data_q[n % 16]);
		chk("store width", dbl, lsu.dbl_q[n % 16]);
		chk("store half", ext, lsu.ext_q[n % 16]);
	endtask : st_chk
	// ==========================================================
	// Scenarios.
	task t_plain;
		int n;
		chk("reset ext valid", 0, evalid);
		chk("reset trap code", 0, tcode);
		wb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped read", 0, rd_val);
		n = lsu.count;
		slow <= 1'b1;
		store_case(6'h2C, 32'h0000_2000, 8'hFF, 1'b1, 6'h07, 3'h0, 1);
		st_chk(n, 32'h0000_1FFC, 64'h1111_2222, 1'b0, 1'b0);
		slow <= 1'b0;
		store_case(6'h2F, 32'h0000_2008, 8'h00, 1'b1, 6'h07, 3'h0, 1);
		st_chk(n + 1, 32'h0000_2008, 64'h3333_4444_1111_2222, 1'b1, 1'b0);
		store_case(6'h2C, 32'h0000_2000, 8'h00, 1'b0, 6'h07, 3'h0, 0);
		$display("test plain stores done");
	endtask : t_plain
	task t_faults;
		store_case(6'h2C, 32'h0000_2002, 8'h00, 1'b1, 6'h07, 3'h1, 0);
		store_case(6'h2F, 32'h0000_2004, 8'h00, 1'b1, 6'h07, 3'h2, 0);
		store_case(6'h2F, 32'h0000_2002, 8'h00, 1'b1, 6'h07, 3'h1, 0);
		wb(1'b0, cond_fp_store_pkg::OFS_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_0002, rd_val & 32'h0000_00FF);
		store_case(6'h2C, 32'h0000_2000, 8'h00, 1'b1, 6'h05, 3'h3, 0);
		store_case(6'h2F, 32'h0000_2000, 8'h00, 1'b1, 6'h06, 3'h3, 0);
		wb(1'b1, cond_fp_store_pkg::OFS_WATCH, 32'h0000_3000);
		store_case(6'h2C, 32'h0000_3000, 8'h00, 1'b0, 6'h27, 3'h5, 0);
		$display("test faults done");
	endtask : t_faults
	task t_simd;
		int n;
		n = lsu.count;
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h11C0_0000);
		chk("ext valid", 1, evalid);
		store_case(6'h2F, 32'h0000_1000, 8'h04, 1'b1, 6'h07, 3'h0, 2);
		st_chk(n, 32'h0000_1010, 64'h3333_4444_1111_2222, 1'b1, 1'b0);
		st_chk(n + 1, 32'h0000_1018, 64'h7777_8888_5555_6666, 1'b1, 1'b1);
		chk("ext valid", 0, evalid);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h11C0_0000);
		store_case(6'h2C, 32'h0000_1000, 8'h02, 1'b1, 6'h07, 3'h0, 2);
		st_chk(n + 3, 32'h0000_100C, 64'h5555_6666, 1'b0, 1'b1);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h11C0_0000);
		store_case(6'h2F, 32'h0000_1004, 8'h00, 1'b1, 6'h07, 3'h1, 0);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h11C0_0000);
		store_case(6'h2C, 32'h0000_1004, 8'h00, 1'b1, 6'h07, 3'h1, 0);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h11C0_0000);
		store_case(6'h2C, 32'h0000_1000, 8'h00, 1'b1, 6'h03, 3'h4, 0);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h11C0_0000);
		store_case(6'h2C, 32'h0000_1000, 8'h00, 1'b1, 6'h0F, 3'h4, 0);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h11C0_0000);
		store_case(6'h2C, 32'h0000_1000, 8'h00, 1'b1, 6'h1F, 3'h0, 2);
		wb(1'b1, cond_fp_store_pkg::OFS_WATCH, 32'h0000_1018);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h11C0_0000);
		store_case(6'h2F, 32'h0000_1000, 8'h04, 1'b0, 6'h27, 3'h5, 0);
		$display("test simd done");
	endtask : t_simd
	task t_prefix;
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h21C0_0000);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h01C0_0000);
		chk("trap pulse", 1, trap_seen);
		chk("trap code", 3'h6, tcode);
		wb(1'b0, cond_fp_store_pkg::OFS_EXT_STATE, 32'h0000_0000);
		chk("ext state valid", 1, rd_val[0]);
		store_case(6'h2C, 32'h0000_2000, 8'h00, 1'b0, 6'h07, 3'h0, 0);
		chk("ext valid", 1, evalid);
		store_case(6'h2C, 32'h0000_2000, 8'h00, 1'b0, 6'h07, 3'h0, 0);
		chk("ext valid", 0, evalid);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h01C0_1FFF);
		chk("trap pulse", 0, trap_seen);
		store_case(6'h2C, 32'h0000_2000, 8'h00, 1'b0, 6'h07, 3'h0, 0);
		chk("ext valid", 0, evalid);
		$display("test prefix done");
	endtask : t_prefix
	task t_gap(input logic [31:0] pc, input logic exp);
		int g;
		wb(1'b1, cond_fp_store_pkg::OFS_PC, 32'h0000_0100);
		wb(1'b1, cond_fp_store_pkg::OFS_INSN, 32'h01C0_0000);
		wb(1'b1, cond_fp_store_pkg::OFS_PC, pc);
		g = gap_count;
		store_case(6'h2C, 32'h0000_2000, 8'h00, 1'b0, 6'h07, 3'h0, 0);
		chk("gap pulse", exp, gap_count - g);
		wb(1'b0, cond_fp_store_pkg::OFS_STATUS, 32'h0000_0000);
		chk("gap status", exp, rd_val[7]);
		$display("test gap done");
	endtask : t_gap
	initial begin
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		wb(1'b1, cond_fp_store_pkg::OFS_DATA_LO, 32'h1111_2222);
		wb(1'b1, cond_fp_store_pkg::OFS_DATA_HI, 32'h3333_4444);
		wb(1'b1, cond_fp_store_pkg::OFS_EXT_LO, 32'h5555_6666);
		wb(1'b1, cond_fp_store_pkg::OFS_EXT_HI, 32'h7777_8888);
		t_plain();
		t_faults();
		t_simd();
		t_prefix();
		t_gap(32'h0000_0104, 1'b0);
		t_gap(32'h0000_0200, 1'b1);
		finish_test();
	end
endmodule : cond_fp_store_and_xar_prefix_bench

// [bench/lsu_model.sv]
// ==========================================================
// Load/store unit stand-in: accepts stores, optionally late.
module lsu_model (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_slow,
	input wire logic i_valid,
	input wire logic [31:0] i_addr,
	input wire logic [63:0] i_data,
	input wire logic i_double,
	input wire logic i_ext,
	output logic o_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] addr_q [16];
	logic [63:0] data_q [16];
	logic dbl_q [16];
	logic ext_q [16];
	int count;
	int waited;
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_ready <= 1'b0;
			count <= 0;
			waited <= 0;
		end else if (i_valid && o_ready) begin
			// Stores are logged strictly in arrival order.
			addr_q[count % 16] <= i_addr;
			data_q[count % 16] <= i_data;
			dbl_q[count % 16] <= i_double;
			ext_q[count % 16] <= i_ext;
			count <= count + 1;
			o_ready <= 1'b0;
			waited <= 0;
		end else if (i_valid) begin
			waited <= waited + 1;
			o_ready <= (waited >= (i_slow ? 3 : 0));
		end
	end
endmodule : lsu_model

// [include/cond_fp_store_pkg.sv]
package cond_fp_store_pkg;
	// ==========================================================
	// Register map, byte addresses on the register bus.
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_INSN = 8'h00;
	localparam logic [7:0] OFS_BASE = 8'h04;
	localparam logic [7:0] OFS_COND = 8'h08;
	localparam logic [7:0] OFS_DATA_LO = 8'h0C;
	localparam logic [7:0] OFS_DATA_HI = 8'h10;
	localparam logic [7:0] OFS_EXT_LO = 8'h14;
	localparam logic [7:0] OFS_EXT_HI = 8'h18;
	localparam logic [7:0] OFS_CTRL = 8'h1C;
	localparam logic [7:0] OFS_WATCH = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_ADDR = 8'h28;
	localparam logic [7:0] OFS_EXT_STATE = 8'h2C;
	localparam logic [7:0] OFS_PC = 8'h30;
	// ==========================================================
	// Control bits.
	localparam int unsigned CTRL_W = 6;
	localparam int unsigned CTRL_PROC_FP_EN = 0;
	localparam int unsigned CTRL_FP_STATUS_EN = 1;
	localparam int unsigned CTRL_CACHEABLE = 2;
	localparam int unsigned CTRL_BYPASS = 3;
	localparam int unsigned CTRL_PHYS_BYPASS = 4;
	localparam int unsigned CTRL_WATCH_EN = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam int unsigned STATUS_GAP_BIT = 7;
	// ==========================================================
	// Instruction encodings.
	localparam logic [1:0] OP_FMT3 = 2'h3;
	localparam logic [1:0] OP_FMT2 = 2'h0;
	localparam logic [5:0] OP3_ST_SINGLE = 6'h2C;
	localparam logic [5:0] OP3_ST_DOUBLE = 6'h2F;
	localparam logic [2:0] OP2_PREFIX = 3'h7;
	localparam int unsigned SLOT_W = 13;
	localparam int unsigned SLOT_SIMD = 12;
	localparam logic [31:0] INSN_STEP = 32'h0000_0004;
	localparam logic [31:0] SINGLE_STEP = 32'h0000_0004;
	localparam logic [31:0] DOUBLE_STEP = 32'h0000_0008;
	// ==========================================================
	// Trap codes and store sequencer states.
	typedef enum logic [2:0] {
		TRAP_NONE = 3'b000,
		TRAP_MISALIGN = 3'b001,
		TRAP_DSTORE_MISALIGN = 3'b010,
		TRAP_FPU_OFF = 3'b011,
		TRAP_DATA_ACCESS = 3'b100,
		TRAP_WATCH = 3'b101,
		TRAP_ILLEGAL_ACTION = 3'b110
	} trap_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BASIC = 2'b01,
		ST_EXT = 2'b10
	} store_state_e;
endpackage : cond_fp_store_pkg

// [logic/cond_fp_store_and_xar_prefix.sv]
// Overview of operation
// - Store class op3 10 1100 is single-width, 10 1111 is double-width.
// - Address is base plus sign-extended short offset shifted left two.
// - Single form writes a single value to a 4-byte aligned address.
// - Double form writes a double value to an 8-byte aligned address.
// - Single form traps as misaligned unless address is multiple of four.
// - Double form traps as misaligned unless address is multiple of four.
// - Non-SIMD double at 4-byte-only alignment raises the double-store trap.
// - Both forms trap when the floating-point unit is disabled.
// - A watchpoint match traps even if the write is suppressed.
// - SIMD form stores basic and extended halves as one instruction.
// - SIMD single stores two singles and needs 8-byte alignment.
// - SIMD double needs 16-byte alignment, only the generic misalign trap.
// - SIMD stores need cacheable space; only physical bypass spaces allowed.
// - SIMD halves keep total store order, basic before extended.
// - Watchpoints are checked separately on basic and extended stores.
// - Prefix is op2 111; combine bit picks one or two instructions.
// - One-instruction prefix with non-zero second fields is not illegal.
// - Prefix while extension state is valid raises the illegal-action trap.
// - Non-consecutive prefix and follower get an inserted trap step.
module cond_fp_store_and_xar_prefix (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	input wire logic i_mem_ready,
	output logic o_mem_valid,
	output logic [31:0] o_mem_addr,
	output logic [63:0] o_mem_data,
	output logic o_mem_double,
	output logic o_mem_ext,
	output logic o_trap_valid,
	output logic [2:0] o_trap_code,
	output logic o_gap_trap,
	output logic o_ext_valid
);
	// ==========================================================
	// State.
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [31:0] base;
		logic [31:0] cond;
		logic [31:0] dlo;
		logic [31:0] dhi;
		logic [31:0] elo;
		logic [31:0] ehi;
		logic [5:0] ctrl;
		logic [31:0] watch;
		logic [31:0] pc;
		logic [31:0] exp_pc;
		logic [7:0] status;
		logic ext_valid;
		logic [12:0] first;
		logic [12:0] second;
		logic second_pend;
		cond_fp_store_pkg::store_state_e state;
		logic simd;
		logic [31:0] ext_addr;
		logic [63:0] ext_data;
		logic mem_valid;
		logic [31:0] mem_addr;
		logic [63:0] mem_data;
		logic mem_double;
		logic mem_ext;
		logic trap_pulse;
		cond_fp_store_pkg::trap_e trap;
		logic gap_pulse;
	} state_s;

	state_s r_reg;
	state_s r_next;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int k = 0; k < 4; k++) begin
			if (sel[k]) begin
				res[8*k +: 8] = new_v[8*k +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// Watchpoints match on an 8-byte granule.
	function automatic logic watch_hit(input logic [31:0] addr,
		input logic [31:0] watch, input logic en);
		return en && (addr[31:3] == watch[31:3]);
	endfunction : watch_hit

	// ==========================================================
	// Decode of the word written to the instruction register.
	logic bus_req, busy, insn_wr, imm_bit, is_cstore, is_double, is_prefix;
	logic [1:0] op;
	logic [5:0] op3;
	logic [2:0] op2;
	logic [7:0] short_signed_offset;
	logic simd, fpu_ok, cache_ok, cond_set, watch_basic, watch_ext;
	logic [31:0] ea;
	logic [31:0] ext_addr;
	logic err_misalign, err_dstore;
	cond_fp_store_pkg::trap_e store_trap;

	assign bus_req = i_wb_cyc && i_wb_stb && !r_reg.ack;
	assign busy = r_reg.state != cond_fp_store_pkg::ST_IDLE;
	assign insn_wr = bus_req && i_wb_we && !busy
		&& (i_wb_adr == cond_fp_store_pkg::OFS_INSN);
	assign op = i_wb_dat[31:30];
	assign op3 = i_wb_dat[24:19];
	assign op2 = i_wb_dat[24:22];
	assign imm_bit = i_wb_dat[13];
	assign short_signed_offset = i_wb_dat[12:5];
	assign is_cstore = (op == cond_fp_store_pkg::OP_FMT3) && imm_bit
		&& ((op3 == cond_fp_store_pkg::OP3_ST_SINGLE)
		|| (op3 == cond_fp_store_pkg::OP3_ST_DOUBLE));
	assign is_double = op3 == cond_fp_store_pkg::OP3_ST_DOUBLE;
	assign is_prefix = (op == cond_fp_store_pkg::OP_FMT2)
		&& (op2 == cond_fp_store_pkg::OP2_PREFIX);
	assign simd = r_reg.ext_valid
		&& r_reg.first[cond_fp_store_pkg::SLOT_SIMD];
	assign ea = r_reg.base + {{22{short_signed_offset[7]}},
		short_signed_offset, 2'b00};
	assign ext_addr = ea + (is_double ? cond_fp_store_pkg::DOUBLE_STEP
		: cond_fp_store_pkg::SINGLE_STEP);
	assign fpu_ok = r_reg.ctrl[cond_fp_store_pkg::CTRL_PROC_FP_EN]
		&& r_reg.ctrl[cond_fp_store_pkg::CTRL_FP_STATUS_EN];
	assign cache_ok = r_reg.ctrl[cond_fp_store_pkg::CTRL_CACHEABLE]
		&& (!r_reg.ctrl[cond_fp_store_pkg::CTRL_BYPASS]
		|| r_reg.ctrl[cond_fp_store_pkg::CTRL_PHYS_BYPASS]);
	assign cond_set = r_reg.cond[31];
	assign watch_basic = watch_hit(ea, r_reg.watch,
		r_reg.ctrl[cond_fp_store_pkg::CTRL_WATCH_EN]);
	assign watch_ext = simd && watch_hit(ext_addr, r_reg.watch,
		r_reg.ctrl[cond_fp_store_pkg::CTRL_WATCH_EN]);
	assign err_dstore = !simd && is_double && (ea[1:0] == 2'b00)
		&& (ea[2] != 1'b0);
	assign err_misalign = simd ? (is_double ? ea[3:0] != 4'h0
		: ea[2:0] != 3'h0) : ea[1:0] != 2'b00;

	// Trap priority: unit disabled, alignment, space, then watchpoint.
	always_comb begin
		if (!fpu_ok) begin
			store_trap = cond_fp_store_pkg::TRAP_FPU_OFF;
		end else if (err_misalign) begin
			store_trap = cond_fp_store_pkg::TRAP_MISALIGN;
		end else if (err_dstore) begin
			store_trap = cond_fp_store_pkg::TRAP_DSTORE_MISALIGN;
		end else if (simd && !cache_ok) begin
			store_trap = cond_fp_store_pkg::TRAP_DATA_ACCESS;
		end else if (watch_basic || watch_ext) begin
			store_trap = cond_fp_store_pkg::TRAP_WATCH;
		end else begin
			store_trap = cond_fp_store_pkg::TRAP_NONE;
		end
	end

	// ==========================================================
	// Next state.
	always_comb begin
		r_next = r_reg;
		r_next.ack = bus_req && !(i_wb_we && busy
			&& (i_wb_adr == cond_fp_store_pkg::OFS_INSN));
		r_next.trap_pulse = 1'b0;
		r_next.gap_pulse = 1'b0;
		if (bus_req && !i_wb_we) begin
			if (i_wb_adr == cond_fp_store_pkg::OFS_BASE) begin
				r_next.rdat = r_reg.base;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_COND) begin
				r_next.rdat = r_reg.cond;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_DATA_LO) begin
				r_next.rdat = r_reg.dlo;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_DATA_HI) begin
				r_next.rdat = r_reg.dhi;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_EXT_LO) begin
				r_next.rdat = r_reg.elo;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_EXT_HI) begin
				r_next.rdat = r_reg.ehi;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_CTRL) begin
				r_next.rdat = {26'h000_0000, r_reg.ctrl};
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_WATCH) begin
				r_next.rdat = r_reg.watch;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_STATUS) begin
				r_next.rdat = {23'h00_0000, busy, r_reg.status};
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_ADDR) begin
				r_next.rdat = ea;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_EXT_STATE) begin
				r_next.rdat = {4'h0, r_reg.second, r_reg.first,
					r_reg.second_pend, r_reg.ext_valid};
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_PC) begin
				r_next.rdat = r_reg.pc;
			end else begin
				r_next.rdat = 32'h0000_0000;
			end
		end
		if (bus_req && i_wb_we) begin
			if (i_wb_adr == cond_fp_store_pkg::OFS_BASE) begin
				r_next.base = merge_bytes(r_reg.base, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_COND) begin
				r_next.cond = merge_bytes(r_reg.cond, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_DATA_LO) begin
				r_next.dlo = merge_bytes(r_reg.dlo, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_DATA_HI) begin
				r_next.dhi = merge_bytes(r_reg.dhi, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_EXT_LO) begin
				r_next.elo = merge_bytes(r_reg.elo, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_EXT_HI) begin
				r_next.ehi = merge_bytes(r_reg.ehi, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_CTRL) begin
				r_next.ctrl = i_wb_sel[0] ? i_wb_dat[5:0] : r_reg.ctrl;
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_WATCH) begin
				r_next.watch = merge_bytes(r_reg.watch, i_wb_dat, i_wb_sel);
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_STATUS) begin
				if (i_wb_sel[0]) begin
					r_next.status = r_reg.status & ~i_wb_dat[7:0];
				end
			end else if (i_wb_adr == cond_fp_store_pkg::OFS_PC) begin
				r_next.pc = merge_bytes(r_reg.pc, i_wb_dat, i_wb_sel);
			end
		end
		// Store sequencer; the basic half completes before the extended one.
		case (r_reg.state)
			cond_fp_store_pkg::ST_BASIC: begin
				if (i_mem_ready) begin
					if (r_reg.simd) begin
						r_next.state = cond_fp_store_pkg::ST_EXT;
						r_next.mem_addr = r_reg.ext_addr;
						r_next.mem_data = r_reg.ext_data;
						r_next.mem_ext = 1'b1;
					end else begin
						r_next.state = cond_fp_store_pkg::ST_IDLE;
						r_next.mem_valid = 1'b0;
					end
				end
			end
			cond_fp_store_pkg::ST_EXT: begin
				if (i_mem_ready) begin
					r_next.state = cond_fp_store_pkg::ST_IDLE;
					r_next.mem_valid = 1'b0;
					r_next.mem_ext = 1'b0;
				end
			end
			default: begin
				r_next.state = cond_fp_store_pkg::ST_IDLE;
			end
		endcase
		if (insn_wr && is_prefix) begin
			if (r_reg.ext_valid) begin
				r_next.trap = cond_fp_store_pkg::TRAP_ILLEGAL_ACTION;
				r_next.trap_pulse = 1'b1;
			end else begin
				// Second fields are accepted even for a one-step prefix.
				r_next.ext_valid = 1'b1;
				r_next.first = {i_wb_dat[28:25], i_wb_dat[21:13]};
				r_next.second = i_wb_dat[12:0];
				r_next.second_pend = i_wb_dat[29];
				r_next.exp_pc = r_reg.pc + cond_fp_store_pkg::INSN_STEP;
			end
		end else if (insn_wr) begin
			if (r_reg.ext_valid) begin
				if (r_reg.pc != r_reg.exp_pc) begin
					r_next.gap_pulse = 1'b1;
				end
				if (r_reg.second_pend) begin
					r_next.first = r_reg.second;
					r_next.second = 13'h0000;
					r_next.second_pend = 1'b0;
					r_next.exp_pc = r_reg.pc + cond_fp_store_pkg::INSN_STEP;
				end else begin
					r_next.ext_valid = 1'b0;
				end
			end
			if (is_cstore) begin
				if (store_trap != cond_fp_store_pkg::TRAP_NONE) begin
					r_next.trap = store_trap;
					r_next.trap_pulse = 1'b1;
				end else if (cond_set) begin
					r_next.state = cond_fp_store_pkg::ST_BASIC;
					r_next.simd = simd;
					r_next.mem_valid = 1'b1;
					r_next.mem_addr = ea;
					r_next.mem_double = is_double;
					r_next.mem_ext = 1'b0;
					r_next.mem_data = is_double ? {r_reg.dhi, r_reg.dlo}
						: {32'h0000_0000, r_reg.dlo};
					r_next.ext_addr = ext_addr;
					r_next.ext_data = is_double ? {r_reg.ehi, r_reg.elo}
						: {32'h0000_0000, r_reg.elo};
				end
				// A clear condition bit leaves memory untouched.
			end
		end
		// Events set sticky status after software clears, so sets win.
		if (r_next.trap_pulse) begin
			r_next.status[r_next.trap] = 1'b1;
		end
		if (r_next.gap_pulse) begin
			r_next.status[cond_fp_store_pkg::STATUS_GAP_BIT] = 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_wb_ack = r_reg.ack;
	assign o_wb_dat = r_reg.rdat;
	assign o_mem_valid = r_reg.mem_valid;
	assign o_mem_addr = r_reg.mem_addr;
	assign o_mem_data = r_reg.mem_data;
	assign o_mem_double = r_reg.mem_double;
	assign o_mem_ext = r_reg.mem_ext;
	assign o_trap_valid = r_reg.trap_pulse;
	assign o_trap_code = r_reg.trap;
	assign o_gap_trap = r_reg.gap_pulse;
	assign o_ext_valid = r_reg.ext_valid;

	// ==========================================================
	// Checks.
	logic st_go;
	assign st_go = insn_wr && is_cstore
		&& (store_trap == cond_fp_store_pkg::TRAP_NONE);

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	decode_store_a: assert property (st_go && cond_set |=> o_mem_valid
		&& o_mem_double == $past(is_double))
		else $error("taken store not issued");
	eff_addr_a: assert property (st_go && cond_set |=>
		o_mem_addr == $past(ea))
		else $error("store address wrong");
	single_write_a: assert property (st_go && cond_set && !is_double
		|=> !o_mem_double && o_mem_addr[1:0] == 2'b00)
		else $error("single store misplaced");
	double_write_a: assert property (st_go && cond_set && is_double
		|=> o_mem_double && o_mem_addr[2:0] == 3'h0)
		else $error("double store misplaced");
	no_write_a: assert property (st_go && !cond_set |=>
		!o_mem_valid && !o_trap_valid)
		else $error("store with clear condition");
	single_align_a: assert property (insn_wr && is_cstore && fpu_ok
		&& !simd && !is_double && ea[1:0] != 2'b00 |=>
		o_trap_valid && o_trap_code == cond_fp_store_pkg::TRAP_MISALIGN)
		else $error("single misalign missed");
	double_trap_a: assert property (insn_wr && is_cstore && fpu_ok
		&& !simd && is_double && ea[1:0] == 2'b00 && ea[2] |=>
		o_trap_code == cond_fp_store_pkg::TRAP_DSTORE_MISALIGN)
		else $error("double store trap missed");
	fpu_off_a: assert property (insn_wr && is_cstore && !fpu_ok |=>
		o_trap_valid && o_trap_code == cond_fp_store_pkg::TRAP_FPU_OFF
		&& !o_mem_valid)
		else $error("disabled unit not trapped");
	watch_trap_a: assert property (insn_wr && is_cstore && fpu_ok
		&& !err_misalign && !err_dstore && (!simd || cache_ok)
		&& watch_basic |=> o_trap_code == cond_fp_store_pkg::TRAP_WATCH)
		else $error("watchpoint missed");
	simd_order_a: assert property (o_mem_valid && !o_mem_ext
		&& r_reg.simd && i_mem_ready |=> o_mem_valid && o_mem_ext)
		else $error("extended half not next");
	simd_space_a: assert property (insn_wr && is_cstore && simd
		&& fpu_ok && !err_misalign && !cache_ok |=>
		o_trap_code == cond_fp_store_pkg::TRAP_DATA_ACCESS)
		else $error("noncacheable simd allowed");
	prefix_illegal_a: assert property (insn_wr && is_prefix
		&& o_ext_valid |=> o_trap_valid
		&& o_trap_code == cond_fp_store_pkg::TRAP_ILLEGAL_ACTION)
		else $error("nested prefix not trapped");
	scope_one_a: assert property (insn_wr && !is_prefix && o_ext_valid
		&& !r_reg.second_pend |=> !o_ext_valid)
		else $error("one-step scope kept");

	simd_pair_c: cover property (o_mem_valid && o_mem_ext && i_mem_ready);
	prefix_two_c: cover property (insn_wr && is_prefix && i_wb_dat[29]);
	watch_skip_c: cover property (st_go == 1'b0 && insn_wr && is_cstore
		&& !cond_set && watch_basic);
	gap_c: cover property (o_gap_trap);
endmodule : cond_fp_store_and_xar_prefix
